// ===== verilog/lbc_ctrl.sv
// logic self-test controller with apb registers, run sequencing and nmi reporting
`include "lbc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module lbc_ctrl #(
	parameter bit DUAL_CORE = 1'b1,
	parameter logic [15:0] RUN_STEPS = 16'(`LBC_RUN_STEPS),
	parameter logic [7:0] MICROS_PER_FULL = 8'h04
) (
	input wire logic MCLK,
	input wire logic RESET_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic CORE_SEL,
	input wire logic NMI_IN,
	output logic CORE1_HALT,
	output logic CORE2_HALT,
	output logic NMI_CORE1,
	output logic NMI_CORE2
);
	lbc_pkg::lbc_top_s r;
	lbc_pkg::lbc_top_s n;
	lbc_eng_if eng ();

	logic acc;
	logic wr;
	logic mapped;
	logic owner_ok;
	logic sem_ok;
	logic start;
	logic [11:0] inj_low;
	logic inj_to;
	logic inj_cmp;
	logic inj_trap;
	logic inj_fault;
	logic [15:0] to_limit;
	logic expired;
	logic last_step;
	logic [31:0] cmp_ref;
	logic mismatch;
	logic [15:0] period;

	// =====================================================
	// sub engines
	lbc_step_gen u_step (
		.MCLK(MCLK),
		.RESET_N(RESET_N),
		.eng(eng.gen)
	);
	lbc_sig_engine u_sig (
		.MCLK(MCLK),
		.RESET_N(RESET_N),
		.eng(eng.sig_end)
	);

	assign eng.run = (r.st == lbc_pkg::LBC_EXEC);
	assign eng.div = r.cfg7[`LBC_DIV_HI:`LBC_DIV_LO];
	assign eng.clear = r.clr;
	assign eng.fault = inj_fault ? r.inj[31:`LBC_INJ_FAULT_LO] : 20'h0;

	// =====================================================
	// apb decode
	assign acc = PSEL && PENABLE;
	assign wr = acc && PWRITE;
	assign PREADY = 1'b1;
	assign mapped = (PADDR[1:0] == 2'h0) && (PADDR <= `LBC_OFF_EXP);
	// core one owns the controller after reset until a semaphore says otherwise
	assign owner_ok = (r.sem == `LBC_SEM_FREE)
		|| (r.sem == `LBC_SEM_CORE2 && CORE_SEL)
		|| ((r.sem == `LBC_SEM_CORE1 || r.sem == `LBC_SEM_RESET) && !CORE_SEL);
	assign sem_ok = (r.sem == `LBC_SEM_RESET) || (r.sem == `LBC_SEM_FREE) || owner_ok;
	assign PSLVERR = acc && (!mapped
		|| (PWRITE && PADDR == `LBC_OFF_SEM && !sem_ok)
		|| (PWRITE && PADDR != `LBC_OFF_SEM && PADDR != `LBC_OFF_NMI_FLAG_REGISTER && !owner_ok));
	assign PRDATA = r.prdata;
	assign start = wr && owner_ok && PADDR == `LBC_OFF_CTRL && PWDATA[`LBC_CTRL_START]
		&& r.st == lbc_pkg::LBC_IDLE;

	// =====================================================
	// injection decode
	assign inj_low = r.inj[`LBC_INJ_LOW_HI:0];
	assign inj_to = (r.inj[31:`LBC_INJ_FAULT_LO] == 20'h0) && inj_low == `LBC_INJ_TIMEOUT;
	assign inj_cmp = (r.inj[31:`LBC_INJ_FAULT_LO] == 20'h0) && inj_low == `LBC_INJ_CMP;
	assign inj_trap = (r.inj[31:`LBC_INJ_FAULT_LO] == 20'h0) && inj_low == `LBC_INJ_TRAP;
	assign inj_fault = (r.inj[31:`LBC_INJ_FAULT_LO] != 20'h0) && inj_low == `LBC_INJ_NONE;

	// the watchdog allows a quarter-rate run plus margin; an armed time-out shortens it
	assign to_limit = inj_to ? `LBC_TO_FORCED : {RUN_STEPS[13:0], 2'b00} + `LBC_TO_MARGIN;
	assign expired = (r.tmr == to_limit);
	assign last_step = eng.step && (r.steps == RUN_STEPS - 16'h1);
	assign cmp_ref = inj_cmp ? (r.expct ^ `LBC_CMP_CORRUPT) : r.expct;
	assign mismatch = (eng.sig != cmp_ref);
	assign period = (eng.div == `LBC_DIV_2) ? 16'h2 : (eng.div == `LBC_DIV_4) ? 16'h4 : 16'h1;

	// the tested core is held for the whole run, including the final compare
	assign CORE1_HALT = (r.st != lbc_pkg::LBC_IDLE) && !r.tester;
	assign CORE2_HALT = (r.st != lbc_pkg::LBC_IDLE) && r.tester;
	assign NMI_CORE1 = r.nmi1;
	assign NMI_CORE2 = r.nmi2;

	// =====================================================
	// next state
	always_comb
	begin
		n = r;
		n.nmi_sync = {r.nmi_sync[0], NMI_IN};
		n.nmi1 = 1'b0;
		n.nmi2 = 1'b0;
		n.clr = 1'b0;
		n.exec_cyc = (r.st == lbc_pkg::LBC_EXEC) ? r.exec_cyc + 16'h1 : 16'h0;

		if (PSEL && !PENABLE)
		begin
			unique case (PADDR)
				`LBC_OFF_GCFG7: n.prdata = r.cfg7;
				`LBC_OFF_INJ: n.prdata = r.inj;
				`LBC_OFF_STAT: n.prdata = {15'h0, r.st != lbc_pkg::LBC_IDLE, r.code};
				`LBC_OFF_NMI_FLAG_REGISTER: n.prdata = {16'h0, r.nmi_flag_register};
				`LBC_OFF_SEM: n.prdata = {30'h0, r.sem};
				`LBC_OFF_SIG: n.prdata = eng.sig;
				`LBC_OFF_EXP: n.prdata = r.expct;
				default: n.prdata = 32'h0;
			endcase
		end

		if (wr && owner_ok)
		begin
			unique case (PADDR)
				`LBC_OFF_GCFG7: n.cfg7 = PWDATA;
				`LBC_OFF_INJ: n.inj = PWDATA;
				`LBC_OFF_EXP: n.expct = PWDATA;
				default: n.cfg7 = r.cfg7;
			endcase
		end
		if (wr && PADDR == `LBC_OFF_SEM && sem_ok)
			n.sem = PWDATA[1:0];
		// write one to clear; an event in the same cycle sets it again below
		if (wr && PADDR == `LBC_OFF_NMI_FLAG_REGISTER)
			n.nmi_flag_register = r.nmi_flag_register & ~PWDATA[15:0];

		unique case (r.st)
			lbc_pkg::LBC_IDLE:
			begin
				if (start && inj_trap)
				begin
					// stopped before execution: nmi to the requester, flags untouched
					n.code = `LBC_CODE_TRAP;
					n.micro = 8'h0;
					n.nmi1 = !CORE_SEL;
					n.nmi2 = CORE_SEL;
				end
				else if (start)
				begin
					n.st = lbc_pkg::LBC_EXEC;
					n.tester = CORE_SEL;
					n.steps = 16'h0;
					n.tmr = 16'h0;
					if (r.micro == 8'h0)
					begin
						n.clr = 1'b1;
						n.code = 16'h0;
					end
				end
			end
			lbc_pkg::LBC_EXEC:
			begin
				n.tmr = r.tmr + 16'h1;
				if (r.nmi_sync[1])
				begin
					// nmi has priority over everything else in the run
					n.st = lbc_pkg::LBC_IDLE;
					n.code = `LBC_CODE_TRAP;
					n.micro = 8'h0;
				end
				else if (expired)
				begin
					n.st = lbc_pkg::LBC_IDLE;
					n.code = `LBC_CODE_TIMEOUT;
					n.micro = 8'h0;
					n.nmi_flag_register[`LBC_FLG_INT] = 1'b1;
					n.nmi_flag_register[`LBC_FLG_CORE1] = !r.tester;
					n.nmi_flag_register[`LBC_FLG_CORE2] = r.tester;
					if (!r.nmi_flag_register[`LBC_FLG_INT])
					begin
						n.nmi1 = DUAL_CORE || !r.tester;
						n.nmi2 = DUAL_CORE || r.tester;
					end
				end
				else if (eng.step)
				begin
					n.steps = r.steps + 16'h1;
					if (last_step)
					begin
						if (r.micro == MICROS_PER_FULL - 8'h1)
							n.st = lbc_pkg::LBC_CMP;
						else
						begin
							n.st = lbc_pkg::LBC_IDLE;
							n.micro = r.micro + 8'h1;
						end
					end
				end
			end
			lbc_pkg::LBC_CMP:
			begin
				n.st = lbc_pkg::LBC_IDLE;
				n.micro = 8'h0;
				if (mismatch && !inj_cmp)
				begin
					n.code = `LBC_CODE_FAULT;
					n.nmi_flag_register[`LBC_FLG_INT] = 1'b1;
					n.nmi_flag_register[`LBC_FLG_CORE1] = !r.tester;
					n.nmi_flag_register[`LBC_FLG_CORE2] = r.tester;
					if (!r.nmi_flag_register[`LBC_FLG_INT])
					begin
						n.nmi1 = DUAL_CORE || !r.tester;
						n.nmi2 = DUAL_CORE || r.tester;
					end
				end
				else
					n.code = `LBC_CODE_PASS;
			end
		endcase
	end

	always_ff @(posedge MCLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			r <= '0;
			r.st <= lbc_pkg::LBC_IDLE;
		end
		else
			r <= n;
	end

	// =====================================================
	// checks
	a_core_held: assert property (@(posedge MCLK) disable iff (!RESET_N)
		r.st != lbc_pkg::LBC_IDLE |-> (CORE1_HALT ^ CORE2_HALT) && !(PSEL && PENABLE && PWRITE && start))
		else $error("tested core not held during run");
	a_run_length: assert property (@(posedge MCLK) disable iff (!RESET_N)
		r.st == lbc_pkg::LBC_EXEC && last_step && !r.nmi_sync[1] && !expired
		|-> r.exec_cyc == RUN_STEPS * period - 16'h1)
		else $error("micro-run length wrong for clock setting");
	a_nmi_stops: assert property (@(posedge MCLK) disable iff (!RESET_N)
		r.st == lbc_pkg::LBC_EXEC && r.nmi_sync[1] |=> r.st == lbc_pkg::LBC_IDLE && !CORE1_HALT && !CORE2_HALT)
		else $error("nmi did not stop the run");
	a_clean_pass: assert property (@(posedge MCLK) disable iff (!RESET_N)
		r.st == lbc_pkg::LBC_CMP && r.inj == 32'h0 && eng.sig == r.expct
		|=> r.code == `LBC_CODE_PASS && !NMI_CORE1 && !NMI_CORE2)
		else $error("clean run did not pass");
	a_timeout_report: assert property (@(posedge MCLK) disable iff (!RESET_N)
		r.st == lbc_pkg::LBC_EXEC && expired && !r.nmi_sync[1] && !r.nmi_flag_register[`LBC_FLG_INT]
		|=> r.code == `LBC_CODE_TIMEOUT && r.nmi_flag_register[`LBC_FLG_INT] && (r.tester ? NMI_CORE2 : NMI_CORE1))
		else $error("time-out not reported");
	a_cmp_silent: assert property (@(posedge MCLK) disable iff (!RESET_N)
		r.st == lbc_pkg::LBC_CMP && inj_cmp
		|=> r.code == `LBC_CODE_PASS && !NMI_CORE1 && !NMI_CORE2 && $stable(r.nmi_flag_register[`LBC_FLG_CORE2:`LBC_FLG_CORE1]))
		else $error("corrupted compare raised a failure");
	a_trap_noflag: assert property (@(posedge MCLK) disable iff (!RESET_N)
		start && inj_trap |=> r.code == `LBC_CODE_TRAP && (NMI_CORE1 ^ NMI_CORE2)
		&& r.st == lbc_pkg::LBC_IDLE && $stable(r.nmi_flag_register))
		else $error("nmi trap misbehaved");
	a_fault_report: assert property (@(posedge MCLK) disable iff (!RESET_N)
		r.st == lbc_pkg::LBC_CMP && mismatch && !inj_cmp && !r.nmi_flag_register[`LBC_FLG_INT]
		|=> r.code == `LBC_CODE_FAULT && (r.tester ? NMI_CORE2 : NMI_CORE1))
		else $error("signature mismatch not reported");
	a_fault_range: assert property (@(posedge MCLK) disable iff (!RESET_N)
		r.st == lbc_pkg::LBC_EXEC && r.inj[31:`LBC_INJ_FAULT_LO] != 20'h0 && inj_low == 12'h0
		|-> eng.fault == r.inj[31:`LBC_INJ_FAULT_LO])
		else $error("logic fault value not applied");
	a_dual_nmi: assert property (@(posedge MCLK) disable iff (!RESET_N)
		DUAL_CORE && $rose(r.nmi_flag_register[`LBC_FLG_INT]) && r.st == lbc_pkg::LBC_IDLE
		|-> NMI_CORE1 && NMI_CORE2 && (r.nmi_flag_register[`LBC_FLG_CORE1] != r.nmi_flag_register[`LBC_FLG_CORE2]))
		else $error("failure nmi not sent to both cores");
	a_sem_lock: assert property (@(posedge MCLK) disable iff (!RESET_N)
		PSEL && PENABLE && PWRITE && PADDR == `LBC_OFF_SEM && r.sem == `LBC_SEM_CORE1 && CORE_SEL
		|=> $stable(r.sem))
		else $error("semaphore changed by non-owner");
endmodule
`default_nettype wire

// ===== include/lbc_cfg.svh
// constants of the logic self-test controller
`ifndef LBC_CFG_SVH
`define LBC_CFG_SVH
`define LBC_OFF_CTRL 8'h00
`define LBC_OFF_GCFG7 8'h04
`define LBC_OFF_INJ 8'h08
`define LBC_OFF_STAT 8'h0c
`define LBC_OFF_NMI_FLAG_REGISTER 8'h10
`define LBC_OFF_SEM 8'h14
`define LBC_OFF_SIG 8'h18
`define LBC_OFF_EXP 8'h1c
`define LBC_CTRL_START 0
`define LBC_DIV_HI 19
`define LBC_DIV_LO 18
`define LBC_DIV_2 2'h1
`define LBC_DIV_4 2'h2
`define LBC_INJ_LOW_HI 11
`define LBC_INJ_FAULT_LO 12
`define LBC_INJ_NONE 12'h000
`define LBC_INJ_TIMEOUT 12'h00a
`define LBC_INJ_CMP 12'h0a0
`define LBC_INJ_TRAP 12'ha00
`define LBC_CODE_PASS 16'h0003
`define LBC_CODE_TIMEOUT 16'h0029
`define LBC_CODE_TRAP 16'h0005
`define LBC_CODE_FAULT 16'h001b
`define LBC_FLG_INT 0
`define LBC_FLG_CORE1 4
`define LBC_FLG_CORE2 5
`define LBC_SEM_RESET 2'h0
`define LBC_SEM_CORE2 2'h1
`define LBC_SEM_CORE1 2'h2
`define LBC_SEM_FREE 2'h3
`define LBC_RUN_NS 2500
`define LBC_CLK_MHZ 100
`define LBC_RUN_STEPS ((`LBC_RUN_NS * `LBC_CLK_MHZ) / 1000)
`define LBC_TO_MARGIN 16'h0010
`define LBC_TO_FORCED 16'h0008
`define LBC_CMP_CORRUPT 32'hffffffff
`define LBC_SEED 32'h00000001
`define LBC_POLY 32'h04c11db7
`endif

// ===== include/lbc_pkg.sv
// types of the logic self-test controller
`default_nettype none
package lbc_pkg;
	typedef enum logic [2:0] {LBC_IDLE = 3'b001, LBC_EXEC = 3'b010, LBC_CMP = 3'b100} lbc_state_e;
	typedef struct packed {
		lbc_state_e st;
		logic [1:0] nmi_sync;
		logic tester;
		logic [15:0] steps;
		logic [15:0] tmr;
		logic [7:0] micro;
		logic [31:0] cfg7;
		logic [31:0] inj;
		logic [15:0] code;
		logic [15:0] nmi_flag_register;
		logic [1:0] sem;
		logic [31:0] expct;
		logic [31:0] prdata;
		logic nmi1;
		logic nmi2;
		logic clr;
		logic [15:0] exec_cyc;
	} lbc_top_s;
	typedef struct packed {
		logic [1:0] cnt;
	} lbc_step_s;
	typedef struct packed {
		logic [31:0] lfsr;
		logic [31:0] misr;
	} lbc_sig_s;
endpackage
`default_nettype wire

// ===== include/lbc_eng_if.sv
// link between the controller and its step and signature engines
`timescale 1ns/1ps
`default_nettype none
interface lbc_eng_if;
	logic run;
	logic [1:0] div;
	logic step;
	logic clear;
	logic [19:0] fault;
	logic [31:0] sig;
	modport ctl (output run, output div, output clear, output fault, input step, input sig);
	modport gen (input run, input div, output step);
	modport sig_end (input step, input clear, input fault, output sig);
endinterface
`default_nettype wire

// ===== verilog/lbc_step_gen.sv
// test clock step generator, full rate or divided by 2 or 4
`include "lbc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module lbc_step_gen (
	input wire logic MCLK,
	input wire logic RESET_N,
	lbc_eng_if.gen eng
);
	lbc_pkg::lbc_step_s r;
	lbc_pkg::lbc_step_s n;
	logic [1:0] last;

	assign last = (eng.div == `LBC_DIV_2) ? 2'h1 : (eng.div == `LBC_DIV_4) ? 2'h3 : 2'h0;
	// a step closes each test clock period, so a divided run lasts exactly two or four times as long
	assign eng.step = eng.run && (r.cnt == last);

	always_comb
	begin
		n = r;
		if (!eng.run || r.cnt == last)
			n.cnt = 2'h0;
		else
			n.cnt = r.cnt + 2'h1;
	end

	always_ff @(posedge MCLK or negedge RESET_N)
	begin
		if (!RESET_N)
			r <= '0;
		else
			r <= n;
	end

	// =====================================================
	// checks
	a_div_quarter: assert property (@(posedge MCLK) disable iff (!RESET_N)
		eng.run && eng.div == `LBC_DIV_4 && eng.step |=> !eng.step [*3])
		else $error("quarter rate step came early");
	a_div_half: assert property (@(posedge MCLK) disable iff (!RESET_N)
		eng.run && eng.div == `LBC_DIV_2 && eng.step |=> !eng.step ##1 (eng.step || !eng.run))
		else $error("half rate step spacing wrong");
endmodule
`default_nettype wire

// ===== verilog/lbc_sig_engine.sv
// pattern source, circuit response and signature register
`include "lbc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module lbc_sig_engine (
	input wire logic MCLK,
	input wire logic RESET_N,
	lbc_eng_if.sig_end eng
);
	lbc_pkg::lbc_sig_s r;
	lbc_pkg::lbc_sig_s n;

	function automatic logic [31:0] shift_poly(input logic [31:0] v);
		shift_poly = {v[30:0], 1'b0} ^ (v[31] ? `LBC_POLY : 32'h0);
	endfunction

	assign eng.sig = r.misr;

	always_comb
	begin
		n.lfsr = eng.clear ? `LBC_SEED : r.lfsr;
		n.misr = eng.clear ? 32'h0 : r.misr;
		// a step in the clearing cycle starts from the seed, so the signature does not depend on the divider
		if (eng.step)
		begin
			// injected fault flips response bits of the logic under test
			n.misr = shift_poly(n.misr) ^ n.lfsr ^ {eng.fault, 12'h000};
			n.lfsr = shift_poly(n.lfsr);
		end
	end

	always_ff @(posedge MCLK or negedge RESET_N)
	begin
		if (!RESET_N)
			r <= '0;
		else
			r <= n;
	end
endmodule
`default_nettype wire

// ===== testbench/lbc_core_pair.sv
// behavioural model of the two cores that face the self-test controller
`timescale 1ns/1ps
`default_nettype none
module lbc_core_pair (
	input wire logic MCLK,
	input wire logic RESET_N,
	input wire logic CORE1_HALT,
	input wire logic CORE2_HALT,
	input wire logic NMI_CORE1,
	input wire logic NMI_CORE2,
	input wire logic nmi_req,
	output logic NMI_IN,
	output int nmi1_cnt,
	output int nmi2_cnt,
	output int halt1_cnt,
	output int halt2_cnt
);
	// ==========================================================
	// memory each core keeps aside for the test, reference only
	localparam int SCRATCH_BASE = 0;
	localparam int SCRATCH_WORDS = 32;
	localparam int STACK_WORDS = 80;
	// ==========================================================
	// nmi source and observation of the controller's outputs
	always_ff @(posedge MCLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			NMI_IN <= 1'b0;
			nmi1_cnt <= 0;
			nmi2_cnt <= 0;
			halt1_cnt <= 0;
			halt2_cnt <= 0;
		end
		else
		begin
			NMI_IN <= nmi_req;
			nmi1_cnt <= nmi1_cnt + int'(NMI_CORE1);
			nmi2_cnt <= nmi2_cnt + int'(NMI_CORE2);
			// a held core runs no program, it only counts stalled cycles
			halt1_cnt <= halt1_cnt + int'(CORE1_HALT);
			halt2_cnt <= halt2_cnt + int'(CORE2_HALT);
		end
	end
endmodule
`default_nettype wire

// ===== testbench/lbc_ctrl_tb_top.sv
// self-checking testbench of the logic self-test controller
`include "lbc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module lbc_ctrl_tb_top;
	// short runs keep the simulation quick
	// sixteen steps leave room for the forced time-out to strike mid-run
	localparam int RS = 16;
	localparam int MF = 2;
	localparam int LIMIT = 20000;
	logic mclk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, core_sel = 0, nmi_req = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata, rd_data, gold;
	logic pready, pslverr, halt1, halt2, nmi1, nmi2, nmi_in, rd_err;
	int nmi1_cnt, nmi2_cnt, halt1_cnt, halt2_cnt, first_len;
	int miscompares = 0, check_count = 0, cyc = 0;
	always #5 mclk = ~mclk;
	lbc_ctrl #(.DUAL_CORE(1'b1), .RUN_STEPS(16'(RS)), .MICROS_PER_FULL(8'(MF))) dut (.MCLK(mclk),
		.RESET_N(reset_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .CORE_SEL(core_sel), .NMI_IN(nmi_in),
		.CORE1_HALT(halt1), .CORE2_HALT(halt2), .NMI_CORE1(nmi1), .NMI_CORE2(nmi2));
	lbc_core_pair cores (.MCLK(mclk), .RESET_N(reset_n), .CORE1_HALT(halt1), .CORE2_HALT(halt2),
		.NMI_CORE1(nmi1), .NMI_CORE2(nmi2), .nmi_req(nmi_req), .NMI_IN(nmi_in), .nmi1_cnt(nmi1_cnt),
		.nmi2_cnt(nmi2_cnt), .halt1_cnt(halt1_cnt), .halt2_cnt(halt2_cnt));
	// ==========================================================
	// reporting
	task automatic stop_test;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == LIMIT)
		begin
			miscompares++;
			stop_test;
		end
	end
	// ==========================================================
	// apb master and register helpers
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic cs,
		output logic [31:0] r, output logic e);
		logic rdy;
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		core_sel <= cs;
		@(posedge mclk);
		penable <= 1'b1;
		// sample the answer mid-cycle, where it is settled, then let the edge take it
		do
		begin
			@(negedge mclk);
			rdy = pready;
			r = prdata;
			e = pslverr;
			@(posedge mclk);
		end
		while (rdy !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic cs, input logic e);
		apb(1'b1, a, d, cs, rd_data, rd_err);
		chk("pslverr", 32'(e), 32'(rd_err));
	endtask
	task automatic rd(input logic [7:0] a, input logic cs, input logic [31:0] exp);
		apb(1'b0, a, 32'h0, cs, rd_data, rd_err);
		chk("prdata", exp, rd_data);
	endtask
	// the host launches runs only from an idle slot of its control loop
	task automatic run_micro(input logic cs);
		int n;
		wr(`LBC_OFF_CTRL, 32'h00000001, cs, 1'b0);
		for (n = 0; n < 100; n++)
		begin
			apb(1'b0, `LBC_OFF_STAT, 32'h0, cs, rd_data, rd_err);
			if (rd_data[16] === 1'b0)
				break;
		end
		chk("run ended", 32'h0, 32'(rd_data[16]));
	endtask
	task automatic full(input logic cs);
		int h;
		h = halt1_cnt + halt2_cnt;
		run_micro(cs);
		first_len = halt1_cnt + halt2_cnt - h;
		repeat (MF - 1) run_micro(cs);
	endtask
	// ==========================================================
	// scenarios
	task automatic t_reset;
		rd(`LBC_OFF_STAT, 1'b0, 32'h0);
		rd(`LBC_OFF_NMI_FLAG_REGISTER, 1'b0, 32'h0);
		rd(`LBC_OFF_SEM, 1'b0, 32'h0);
		apb(1'b0, 8'h20, 32'h0, 1'b0, rd_data, rd_err);
		chk("unmapped err", 32'h1, 32'(rd_err));
		chk("unmapped data", 32'h0, rd_data);
		$display("test reset done");
	endtask
	task automatic t_clean;
		int n1;
		n1 = nmi1_cnt + nmi2_cnt;
		wr(`LBC_OFF_EXP, 32'h0, 1'b0, 1'b0);
		wr(`LBC_OFF_INJ, 32'h000000a0, 1'b0, 1'b0);
		full(1'b0);
		rd(`LBC_OFF_STAT, 1'b0, 32'(`LBC_CODE_PASS));
		rd(`LBC_OFF_NMI_FLAG_REGISTER, 1'b0, 32'h0);
		apb(1'b0, `LBC_OFF_SIG, 32'h0, 1'b0, gold, rd_err);
		wr(`LBC_OFF_EXP, gold, 1'b0, 1'b0);
		wr(`LBC_OFF_INJ, 32'h0, 1'b0, 1'b0);
		full(1'b0);
		rd(`LBC_OFF_STAT, 1'b0, 32'(`LBC_CODE_PASS));
		chk("nmi count", 32'(n1), 32'(nmi1_cnt + nmi2_cnt));
		$display("test clean done");
	endtask
	task automatic t_div;
		int d;
		for (d = 0; d < 3; d++)
		begin
			wr(`LBC_OFF_GCFG7, 32'(d) << `LBC_DIV_LO, 1'b0, 1'b0);
			full(1'b0);
			chk("halt cycles", 32'(RS << d), 32'(first_len));
			chk("other halt", 32'h0, 32'(halt2_cnt));
			rd(`LBC_OFF_STAT, 1'b0, 32'(`LBC_CODE_PASS));
		end
		wr(`LBC_OFF_GCFG7, 32'h0, 1'b0, 1'b0);
		$display("test divider done");
	endtask
	task automatic t_fail(input string nm, input logic [31:0] code, input logic cs, input logic [31:0] st,
		input logic [31:0] flg, input logic fulltest);
		int n1, n2;
		wr(`LBC_OFF_NMI_FLAG_REGISTER, 32'h0000ffff, cs, 1'b0);
		rd(`LBC_OFF_NMI_FLAG_REGISTER, cs, 32'h0);
		n1 = nmi1_cnt;
		n2 = nmi2_cnt;
		wr(`LBC_OFF_INJ, code, cs, 1'b0);
		if (fulltest)
			full(cs);
		else
			run_micro(cs);
		rd(`LBC_OFF_STAT, cs, st);
		rd(`LBC_OFF_NMI_FLAG_REGISTER, cs, flg);
		chk("nmi core one", 32'(n1 + (flg != 0 || cs == 1'b0 && st == 32'(`LBC_CODE_TRAP))), 32'(nmi1_cnt));
		chk("nmi core two", 32'(n2 + (flg != 0)), 32'(nmi2_cnt));
		$display("test %s done", nm);
	endtask
	task automatic t_nmi;
		int n, c;
		c = nmi1_cnt;
		wr(`LBC_OFF_INJ, 32'h0, 1'b0, 1'b0);
		wr(`LBC_OFF_GCFG7, 32'(`LBC_DIV_4) << `LBC_DIV_LO, 1'b0, 1'b0);
		wr(`LBC_OFF_CTRL, 32'h00000001, 1'b0, 1'b0);
		for (n = 0; n < 20 && halt1 !== 1'b1; n++)
			@(posedge mclk);
		nmi_req <= 1'b1;
		repeat (8) @(posedge mclk);
		chk("halt after nmi", 32'h0, 32'(halt1));
		nmi_req <= 1'b0;
		rd(`LBC_OFF_STAT, 1'b0, 32'(`LBC_CODE_TRAP));
		chk("nmi out", 32'(c), 32'(nmi1_cnt));
		wr(`LBC_OFF_GCFG7, 32'h0, 1'b0, 1'b0);
		$display("test nmi stop done");
	endtask
	task automatic t_sem;
		wr(`LBC_OFF_SEM, 32'(`LBC_SEM_CORE1), 1'b0, 1'b0);
		wr(`LBC_OFF_INJ, 32'h0, 1'b1, 1'b1);
		wr(`LBC_OFF_SEM, 32'(`LBC_SEM_CORE2), 1'b1, 1'b1);
		rd(`LBC_OFF_SEM, 1'b1, 32'(`LBC_SEM_CORE1));
		wr(`LBC_OFF_SEM, 32'(`LBC_SEM_FREE), 1'b0, 1'b0);
		wr(`LBC_OFF_SEM, 32'(`LBC_SEM_CORE2), 1'b1, 1'b0);
		wr(`LBC_OFF_INJ, 32'h0, 1'b0, 1'b1);
		t_fail("core two timeout", 32'h0000000a, 1'b1, 32'(`LBC_CODE_TIMEOUT), 32'h21, 1'b0);
		$display("test semaphore done");
	endtask
	initial
	begin
		repeat (12) @(posedge mclk);
		reset_n <= 1'b1;
		t_reset;
		t_clean;
		t_div;
		t_fail("fault 2000", 32'h00002000, 1'b0, 32'(`LBC_CODE_FAULT), 32'h11, 1'b1);
		t_fail("fault fffff000", 32'hfffff000, 1'b0, 32'(`LBC_CODE_FAULT), 32'h11, 1'b1);
		t_fail("fault 1000", 32'h00001000, 1'b0, 32'(`LBC_CODE_FAULT), 32'h11, 1'b1);
		t_fail("timeout", 32'h0000000a, 1'b0, 32'(`LBC_CODE_TIMEOUT), 32'h11, 1'b0);
		t_fail("trap", 32'h00000a00, 1'b0, 32'(`LBC_CODE_TRAP), 32'h0, 1'b0);
		t_nmi;
		t_sem;
		stop_test;
	end
endmodule
`default_nettype wire
